// ===== hdl/pts_client_end.sv
// client end: drives packet requests and the time-of-day counter
`timescale 1ns/1ns
module pts_client_end (
  input wire logic clk_i,
  input wire logic reset_i,
  pts_link_if.client link,
  input wire logic send_i,
  input wire pts_pkg::pts_mode_e mode_i,
  input wire logic [pts_pkg::FP_W-1:0] fingerprint_i,
  input wire logic [pts_pkg::OFS_W-1:0] offset_i,
  input wire pts_pkg::pts_cksum_e cksum_i,
  input wire logic fmt_v1_i,
  input wire logic fmt_short_i,
  input wire logic asym_i,
  input wire logic [pts_pkg::LONG_W-1:0] ingress_i,
  input wire logic [pts_pkg::SHORT_W-1:0] corr_i,
  input wire logic [pts_pkg::LONG_W-1:0] tick_i,
  output logic [pts_pkg::LONG_W-1:0] stamp_o,
  output logic [pts_pkg::FP_W-1:0] stamp_fp_o,
  output logic stamp_valid_o
);
  import pts_pkg::*;
  typedef struct packed {
    logic [LONG_W-1:0] tod;
    logic [SHORT_W-1:0] tod_short;
    logic sop;
    logic [2:0] mode;
    logic [FP_W-1:0] fp;
    logic [OFS_W-1:0] ofs;
    logic [1:0] ck;
    logic v1;
    logic fs;
    logic asym;
    logic [LONG_W-1:0] ing;
    logic [SHORT_W-1:0] corr;
    logic [LONG_W-1:0] st;
    logic [FP_W-1:0] st_fp;
    logic st_v;
  } pts_cl_s;
  pts_cl_s s_q, s_d;
  logic [LONG_W-1:0] tod_next;

  pts_time_add u_tick (
    .a_i(s_q.tod),
    .b_i(tick_i),
    .sum_o(tod_next)
  );

  // =====================================================================
  // time counter advances each cycle; one request per packet, held with sop only
  always_comb begin
    s_d = s_q;
    s_d.tod = tod_next; // RL15
    s_d.tod_short = s_q.tod_short + {tick_i[NS_LO+47:NS_LO], tick_i[FR_HI:0]}; // RL22
    s_d.sop = send_i; // RL2
    s_d.mode = send_i ? 3'(mode_i) : 3'h0; // RL1
    s_d.fp = fingerprint_i;
    s_d.ofs = offset_i; // RL5 RL6
    s_d.ck = 2'(cksum_i);
    s_d.v1 = fmt_v1_i;
    s_d.fs = fmt_short_i; // RL17
    s_d.asym = asym_i;
    s_d.ing = ingress_i; // RL12
    s_d.corr = corr_i;
    s_d.st_v = link.exit_stamp_long_strobe;
    if (link.exit_stamp_long_strobe) begin
      s_d.st = link.exit_stamp_long_out;
      s_d.st_fp = link.fp_long_out;
    end
  end

  // registered state
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.tx_clock_time_long_in = s_q.tod;
  assign link.tx_clock_time_short_in = s_q.tod_short;
  assign link.sop = s_q.sop;
  assign link.two_step_req = s_q.mode[0];
  assign link.insert_req = s_q.mode[1];
  assign link.correct_req = s_q.mode[2];
  assign link.fingerprint = s_q.fp;
  assign link.stamp_offset = s_q.ofs;
  assign link.corr_offset = s_q.ofs;
  assign link.cksum_zero = s_q.ck[0]; // RL7
  assign link.cksum_fix = s_q.ck[1];
  assign link.fmt_v1 = s_q.v1;
  assign link.fmt_short = s_q.fs;
  assign link.asym_include = s_q.asym;
  assign link.ingress_long = s_q.ing;
  assign link.ingress_short = {s_q.ing[NS_LO+47:NS_LO], s_q.ing[FR_HI:0]};
  assign link.corr_in = s_q.corr;
  assign stamp_o = s_q.st;
  assign stamp_fp_o = s_q.st_fp;
  assign stamp_valid_o = s_q.st_v;
endmodule // pts_client_end

// ===== hdl/pts_link_if.sv
// interface joining the client end and the stamp unit
`timescale 1ns/1ns
interface pts_link_if;
  import pts_pkg::*;
  logic sop;
  logic two_step_req;
  logic insert_req;
  logic correct_req;
  logic [FP_W-1:0] fingerprint;
  logic [OFS_W-1:0] stamp_offset;
  logic [OFS_W-1:0] corr_offset;
  logic cksum_zero;
  logic cksum_fix;
  logic fmt_v1;
  logic fmt_short;
  logic asym_include;
  logic [LONG_W-1:0] ingress_long;
  logic [SHORT_W-1:0] ingress_short;
  logic [SHORT_W-1:0] corr_in;
  logic [LONG_W-1:0] tx_clock_time_long_in;
  logic [SHORT_W-1:0] tx_clock_time_short_in;
  logic exit_stamp_long_strobe;
  logic exit_stamp_short_strobe;
  logic [LONG_W-1:0] exit_stamp_long_out;
  logic [SHORT_W-1:0] exit_stamp_short_out;
  logic [FP_W-1:0] fp_long_out;
  logic [FP_W-1:0] fp_short_out;
  logic edit_strobe;
  logic [1:0] edit_kind;
  logic [OFS_W-1:0] edit_offset;
  logic [SHORT_W-1:0] edit_value;
  logic [1:0] edit_cksum;

  modport device (
    input sop, two_step_req, insert_req, correct_req, fingerprint, stamp_offset, corr_offset,
    input cksum_zero, cksum_fix, fmt_v1, fmt_short, asym_include, ingress_long, ingress_short,
    input corr_in, tx_clock_time_long_in, tx_clock_time_short_in,
    output exit_stamp_long_strobe, exit_stamp_short_strobe, exit_stamp_long_out,
    output exit_stamp_short_out, fp_long_out, fp_short_out,
    output edit_strobe, edit_kind, edit_offset, edit_value, edit_cksum
  );
  modport client (
    output sop, two_step_req, insert_req, correct_req, fingerprint, stamp_offset, corr_offset,
    output cksum_zero, cksum_fix, fmt_v1, fmt_short, asym_include, ingress_long, ingress_short,
    output corr_in, tx_clock_time_long_in, tx_clock_time_short_in,
    input exit_stamp_long_strobe, exit_stamp_short_strobe, exit_stamp_long_out,
    input exit_stamp_short_out, fp_long_out, fp_short_out,
    input edit_strobe, edit_kind, edit_offset, edit_value, edit_cksum
  );
endinterface

// ===== hdl/pts_pkg.sv
// shared constants and types for the transmit precision-time stamp unit
package pts_pkg;
  // =====================================================================
  // widths and time formats
  localparam int FP_W = 8;
  localparam int OFS_W = 16;
  localparam int LONG_W = 96;
  localparam int SHORT_W = 64;
  localparam int SEC_HI = 95;
  localparam int SEC_LO = 48;
  localparam int NS_HI = 47;
  localparam int NS_LO = 16;
  localparam int FR_HI = 15;
  localparam int V1_SEC_LO = 32;
  localparam logic [31:0] NS_WRAP = 32'h3B9ACA00;
  // =====================================================================
  // timing and depths
  localparam logic [95:0] CORE_LATENCY = 96'h000000000000_00000040_0000;
  localparam logic [3:0] PIPE_DEPTH = 4'h4;
  localparam int ORDER_DEPTH = 4;
  localparam logic [95:0] TOD_RESET = 96'h0;
  // =====================================================================
  // software register map of the device end
  localparam logic [3:0] ADDR_EXTRA = 4'h0;
  localparam logic [3:0] ADDR_ASYM = 4'h1;
  localparam logic [3:0] ADDR_CFG = 4'h2;
  localparam logic [3:0] ADDR_STAT = 4'h3;
  localparam int CFG_LONG_EN = 0;
  localparam int CFG_SHORT_EN = 1;
  localparam logic [1:0] CFG_RESET = 2'h3;

  typedef enum logic [2:0] {
    MODE_TWO_STEP = 3'h1,
    MODE_INSERT = 3'h2,
    MODE_CORRECT = 3'h4
  } pts_mode_e;

  typedef enum logic [1:0] {
    CK_KEEP = 2'h0,
    CK_ZERO = 2'h1,
    CK_FIX = 2'h2
  } pts_cksum_e;
endpackage

// ===== hdl/pts_stamp_unit.sv
// device end: transmit timestamp unit with exit-time arithmetic
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
// Function
// RL1 - client raises exactly one mode request
// RL2 - requests ride sop; two at once undefined
// RL3 - two-step returns exit stamp, packet untouched
// RL4 - two-step ignores one-step controls
// RL5 - insert mode overwrites stamp at offset
// RL6 - correct mode rewrites correction at offset
// RL7 - checksum cleared, fixed or kept
// RL8 - fingerprint echoed with stamp strobe
// RL9 - exit = entry + latency + extra
// RL10 - entry time sampled at packet entry
// RL11 - correction = in + residence + asymmetry
// RL12 - residence = exit minus ingress stamp
// RL13 - asymmetry added only when client asks
// RL14 - correct mode never inserts exit time
// RL15 - time source updates every cycle
// RL16 - short-only build supports correction only
// RL17 - format selects choose per packet
// RL18 - compute long; insert V1 when asked
// RL19 - long layout seconds, nanoseconds, fraction
// RL20 - V1 layout seconds over nanoseconds
// RL21 - short layout nanoseconds over fraction
// RL22 - short ports use short layout
// RL23 - carry fraction and nanosecond overflow
// RL24 - two-step stamps return in order
module pts_stamp_unit (
  input wire logic clk_i,
  input wire logic reset_i,
  pts_link_if.device link,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o
);
  import pts_pkg::*;
  typedef struct packed {
    logic [31:0] extra;
    logic [31:0] asym;
    logic [1:0] cfg;
    logic [31:0] rdata;
    logic [15:0] served;
    logic [ORDER_DEPTH-1:0] vld;
    logic [ORDER_DEPTH-1:0][2:0] mode;
    logic [ORDER_DEPTH-1:0][3:0] age;
    logic [ORDER_DEPTH-1:0][LONG_W-1:0] exit_t;
    logic [ORDER_DEPTH-1:0][LONG_W-1:0] ing;
    logic [ORDER_DEPTH-1:0][SHORT_W-1:0] corr;
    logic [ORDER_DEPTH-1:0][FP_W-1:0] fp;
    logic [ORDER_DEPTH-1:0][OFS_W-1:0] ofs;
    logic [ORDER_DEPTH-1:0][1:0] ck;
    logic [ORDER_DEPTH-1:0] v1;
    logic [ORDER_DEPTH-1:0] fs;
    logic [ORDER_DEPTH-1:0] asym_on;
    logic [1:0] wp;
    logic [1:0] rp;
    logic l_stb;
    logic s_stb;
    logic [LONG_W-1:0] l_out;
    logic [SHORT_W-1:0] s_out;
    logic [FP_W-1:0] fp_out;
    logic e_stb;
    logic [1:0] e_kind;
    logic [OFS_W-1:0] e_ofs;
    logic [SHORT_W-1:0] e_val;
    logic [1:0] e_ck;
  } pts_st_s;
  pts_st_s s_q, s_d;
  logic [LONG_W-1:0] lat_sum;
  logic [LONG_W-1:0] exit_entry;
  logic [LONG_W-1:0] extra_long;
  logic [LONG_W-1:0] short_as_long;

  // =====================================================================
  // exit time: entry plus core latency plus extra latency
  assign extra_long = {64'h0, s_q.extra};
  // short time source mapped into long layout when only that format is present
  assign short_as_long = {48'h0, link.tx_clock_time_short_in[47:16], link.tx_clock_time_short_in[15:0]}; // RL22

  pts_time_add u_lat (
    .a_i(CORE_LATENCY),
    .b_i(extra_long),
    .sum_o(lat_sum)
  );

  pts_time_add u_exit (
    .a_i(s_q.cfg[CFG_LONG_EN] ? link.tx_clock_time_long_in : short_as_long), // RL10
    .b_i(lat_sum),
    .sum_o(exit_entry) // RL9
  );

  // =====================================================================
  // per-packet pipeline: capture at sop, release after a fixed delay in order
  always_comb begin
    logic [2:0] req;
    logic [1:0] h;
    logic [LONG_W-1:0] x;
    logic [SHORT_W-1:0] xs;
    logic [SHORT_W-1:0] is;
    logic [SHORT_W-1:0] res;
    logic [SHORT_W-1:0] asy;
    logic [47:0] xn;
    logic [47:0] inn;
    is = '0;
    res = '0;
    asy = '0;
    s_d = s_q;
    req = {link.correct_req, link.insert_req, link.two_step_req};
    h = s_q.rp;
    x = s_q.exit_t[h];
    // seconds folded into nanoseconds so a short value can span more than one second
    xn = x[SEC_HI:SEC_LO] * {16'h0, NS_WRAP} + {16'h0, x[NS_HI:NS_LO]}; // RL21
    inn = s_q.ing[h][SEC_HI:SEC_LO] * {16'h0, NS_WRAP} + {16'h0, s_q.ing[h][NS_HI:NS_LO]};
    xs = {xn, x[FR_HI:0]}; // RL21
    s_d.l_stb = 1'b0;
    s_d.s_stb = 1'b0;
    s_d.e_stb = 1'b0;
    s_d.rdata = 32'h0;
    for (int i = 0; i < ORDER_DEPTH; i++) begin
      if (s_q.vld[i] && s_q.age[i] != PIPE_DEPTH) begin
        s_d.age[i] = s_q.age[i] + 4'h1;
      end
    end
    // head leaves once its delay has elapsed, keeping acceptance order
    if (s_q.vld[h] && s_q.age[h] == PIPE_DEPTH) begin // RL24
      s_d.vld[h] = 1'b0;
      s_d.rp = s_q.rp + 2'h1;
      s_d.served = s_q.served + 16'h1;
      unique case (s_q.mode[h])
        MODE_TWO_STEP: begin
          s_d.l_stb = s_q.cfg[CFG_LONG_EN]; // RL3
          s_d.s_stb = s_q.cfg[CFG_SHORT_EN]; // RL3 RL22
          s_d.l_out = x; // RL19
          s_d.s_out = xs; // RL21
          s_d.fp_out = s_q.fp[h]; // RL8
        end
        MODE_INSERT: begin
          s_d.e_stb = 1'b1; // RL5
          s_d.e_kind = 2'h1;
          s_d.e_ofs = s_q.ofs[h];
          s_d.e_val = s_q.v1[h] ? {x[SEC_LO+31:SEC_LO], x[NS_HI:NS_LO]} : x[SEC_LO+15:0]; // RL18 RL20
          s_d.e_ck = s_q.ck[h]; // RL7
        end
        MODE_CORRECT: begin
          is = {inn, s_q.ing[h][FR_HI:0]};
          if (s_q.fs[h]) begin
            is = s_q.ing[h][SHORT_W-1:0]; // RL17 RL22
          end
          res = xs - is; // RL12 RL14
          asy = s_q.asym_on[h] ? {16'h0, s_q.asym, 16'h0} : 64'h0; // RL13
          s_d.e_stb = 1'b1; // RL6
          s_d.e_kind = 2'h2;
          s_d.e_ofs = s_q.ofs[h];
          s_d.e_val = s_q.corr[h] + res + asy; // RL11
          s_d.e_ck = s_q.ck[h]; // RL7
        end
        default: begin
          s_d.e_stb = 1'b0;
        end
      endcase
    end
    // capture at start of packet; the short-only build refuses all but correction
    if (link.sop && req != 3'h0 && !s_q.vld[s_q.wp]
        && (s_q.cfg[CFG_LONG_EN] || req == 3'(MODE_CORRECT))) begin // RL16
      s_d.vld[s_q.wp] = 1'b1;
      s_d.age[s_q.wp] = 4'h1;
      s_d.mode[s_q.wp] = req;
      s_d.exit_t[s_q.wp] = exit_entry;
      s_d.fp[s_q.wp] = link.fingerprint;
      // short ingress kept in the low 64 bits when that format is chosen
      s_d.ing[s_q.wp] = (link.fmt_short || !s_q.cfg[CFG_LONG_EN]) ? {32'h0, link.ingress_short}
        : link.ingress_long; // RL17
      s_d.corr[s_q.wp] = link.corr_in;
      // two-step drops every one-step control
      s_d.ofs[s_q.wp] = link.insert_req ? link.stamp_offset : (link.correct_req ? link.corr_offset : 16'h0); // RL4
      s_d.ck[s_q.wp] = link.two_step_req ? 2'(CK_KEEP) : {link.cksum_fix, link.cksum_zero}; // RL4 RL7
      s_d.v1[s_q.wp] = !link.two_step_req && link.fmt_v1;
      s_d.fs[s_q.wp] = !link.two_step_req && (link.fmt_short || !s_q.cfg[CFG_LONG_EN]);
      s_d.asym_on[s_q.wp] = link.correct_req && link.asym_include; // RL13
      s_d.wp = s_q.wp + 2'h1;
    end
    // software port
    if (wr_i) begin
      unique case (addr_i)
        ADDR_EXTRA: s_d.extra = wdata_i; // RL9
        ADDR_ASYM: s_d.asym = wdata_i;
        ADDR_CFG: s_d.cfg = wdata_i[1:0];
        default: s_d.cfg = s_d.cfg;
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        ADDR_EXTRA: s_d.rdata = s_q.extra;
        ADDR_ASYM: s_d.rdata = s_q.asym;
        ADDR_CFG: s_d.rdata = {30'h0, s_q.cfg};
        ADDR_STAT: s_d.rdata = {12'h0, s_q.vld, s_q.served};
        default: s_d.rdata = 32'h0;
      endcase
    end
  end

  // registered state; config comes up with both formats on
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q <= '0;
      s_q.cfg <= CFG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.exit_stamp_long_strobe = s_q.l_stb;
  assign link.exit_stamp_short_strobe = s_q.s_stb;
  assign link.exit_stamp_long_out = s_q.l_out;
  assign link.exit_stamp_short_out = s_q.s_out;
  assign link.fp_long_out = s_q.fp_out;
  assign link.fp_short_out = s_q.fp_out;
  assign link.edit_strobe = s_q.e_stb;
  assign link.edit_kind = s_q.e_kind;
  assign link.edit_offset = s_q.e_ofs;
  assign link.edit_value = s_q.e_val;
  assign link.edit_cksum = s_q.e_ck;
  assign rdata_o = s_q.rdata;
endmodule // pts_stamp_unit

// ===== hdl/pts_time_add.sv
// 96-bit time adder with nanosecond wrap into seconds
`timescale 1ns/1ns
module pts_time_add (
  input wire logic [pts_pkg::LONG_W-1:0] a_i,
  input wire logic [pts_pkg::LONG_W-1:0] b_i,
  output logic [pts_pkg::LONG_W-1:0] sum_o
);
  import pts_pkg::*;
  // =====================================================================
  // field adder; b's nanoseconds must stay below one billion
  always_comb begin
    logic [16:0] fr;
    logic [33:0] ns;
    logic [47:0] sec;
    fr = {1'b0, a_i[FR_HI:0]} + {1'b0, b_i[FR_HI:0]}; // RL23
    ns = {2'b0, a_i[NS_HI:NS_LO]} + {2'b0, b_i[NS_HI:NS_LO]} + {33'h0, fr[16]}; // RL23
    sec = a_i[SEC_HI:SEC_LO] + b_i[SEC_HI:SEC_LO];
    if (ns >= {2'b0, NS_WRAP}) begin
      ns = ns - {2'b0, NS_WRAP}; // RL19
      sec = sec + 48'h1; // RL23
    end
    sum_o = {sec, ns[31:0], fr[15:0]};
  end
endmodule // pts_time_add

// ===== testbench/pts_link_props.sv
// concurrent checks on the link between client end and stamp unit
`timescale 1ns/1ns
module pts_link_props (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic sop,
  input wire logic two_step_req,
  input wire logic insert_req,
  input wire logic correct_req,
  input wire logic [pts_pkg::FP_W-1:0] fingerprint,
  input wire logic cksum_zero,
  input wire logic cksum_fix,
  input wire logic exit_stamp_long_strobe,
  input wire logic [pts_pkg::LONG_W-1:0] exit_stamp_long_out,
  input wire logic [pts_pkg::FP_W-1:0] fp_long_out,
  input wire logic edit_strobe,
  input wire logic [1:0] edit_kind,
  input wire logic [1:0] edit_cksum
);
  import pts_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ===================================================================
  // answers trace back to the request taken five cycles before
  a_stamp_from_req:
    assert property (exit_stamp_long_strobe |-> $past(sop && two_step_req, 5)) else $error("stray stamp strobe");
  a_fp_echo:
    assert property (exit_stamp_long_strobe |-> fp_long_out == $past(fingerprint, 5)) else $error("fingerprint lost");
  a_edit_from_req:
    assert property (edit_strobe |-> $past(sop && (insert_req || correct_req), 5)) else $error("stray edit");
  a_insert_kind:
    assert property (edit_strobe && edit_kind == 2'h1 |-> $past(insert_req, 5)) else $error("wrong insert kind");
  a_correct_kind:
    assert property (edit_strobe && edit_kind == 2'h2 |-> $past(correct_req, 5)) else $error("wrong correct kind");
  a_cksum_follow:
    assert property (edit_strobe |-> edit_cksum == $past({cksum_fix, cksum_zero}, 5)) else $error("checksum mode lost");
  // two-step never edits the packet, correction never reports the exit time
  a_two_step_clean:
    assert property (sop && two_step_req |-> ##5 !edit_strobe) else $error("two-step packet edited");
  a_correct_no_stamp:
    assert property (sop && correct_req |-> ##5 !exit_stamp_long_strobe) else $error("correction gave a stamp");
  a_ns_in_range:
    assert property (exit_stamp_long_strobe |-> exit_stamp_long_out[47:16] < NS_WRAP) else $error("ns field overflow");
endmodule // pts_link_props

// ===== testbench/pts_stamp_unit_tb_top.sv
// self-checking bench for the client end and the stamp unit joined by the link
`timescale 1ns/1ns
module pts_stamp_unit_tb_top;
  import pts_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic send_i = 1'b0;
  pts_mode_e mode_i = MODE_TWO_STEP;
  logic [FP_W-1:0] fingerprint_i = '0;
  logic [OFS_W-1:0] offset_i = '0;
  pts_cksum_e cksum_i = CK_KEEP;
  logic fmt_v1_i = 1'b0;
  logic fmt_short_i = 1'b0;
  logic asym_i = 1'b0;
  logic [LONG_W-1:0] ingress_i = '0;
  logic [SHORT_W-1:0] corr_i = '0;
  logic [LONG_W-1:0] tick_i = '0;
  logic [3:0] addr_i = '0;
  logic [31:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [LONG_W-1:0] stamp_o;
  logic [FP_W-1:0] stamp_fp_o;
  logic stamp_valid_o;
  int err_total = 0;
  int checks_done = 0;
  int i;
  logic cfg_long = 1'b1;
  logic [31:0] extra_m = '0;
  logic [31:0] asym_m = '0;
  logic [63:0] cx;
  logic [95:0] ex;
  logic [95:0] last_long = '0;
  logic [103:0] st;
  logic [84:0] ed;
  logic [103:0] stamp_q[$];
  logic [84:0] edit_q[$];
  logic [SHORT_W-1:0] corr_seen[$];

  pts_link_if link();
  pts_client_end i_pts_client_end (.clk_i(clk_i), .reset_i(reset_i), .link(link), .send_i(send_i),
    .mode_i(mode_i), .fingerprint_i(fingerprint_i), .offset_i(offset_i), .cksum_i(cksum_i), .fmt_v1_i(fmt_v1_i),
    .fmt_short_i(fmt_short_i), .asym_i(asym_i), .ingress_i(ingress_i), .corr_i(corr_i), .tick_i(tick_i),
    .stamp_o(stamp_o), .stamp_fp_o(stamp_fp_o), .stamp_valid_o(stamp_valid_o));
  pts_stamp_unit i_pts_stamp_unit (.clk_i(clk_i), .reset_i(reset_i), .link(link), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
  pts_link_props i_pts_link_props (.clk_i(clk_i), .reset_i(reset_i), .sop(link.sop),
    .two_step_req(link.two_step_req), .insert_req(link.insert_req), .correct_req(link.correct_req),
    .fingerprint(link.fingerprint), .cksum_zero(link.cksum_zero), .cksum_fix(link.cksum_fix),
    .exit_stamp_long_strobe(link.exit_stamp_long_strobe), .exit_stamp_long_out(link.exit_stamp_long_out),
    .fp_long_out(link.fp_long_out), .edit_strobe(link.edit_strobe), .edit_kind(link.edit_kind),
    .edit_cksum(link.edit_cksum));

  // ===================================================================
  // reference arithmetic: fraction carries into ns, ns wraps into seconds
  function automatic logic [95:0] tadd(input logic [95:0] a, input logic [95:0] b);
    logic [16:0] fr;
    logic [33:0] ns;
    logic [47:0] s;
    fr = {1'b0, a[15:0]} + {1'b0, b[15:0]};
    ns = {2'h0, a[47:16]} + {2'h0, b[47:16]} + {33'h0, fr[16]};
    s = a[95:48] + b[95:48];
    if (ns >= {2'h0, NS_WRAP}) begin
      ns = ns - {2'h0, NS_WRAP};
      s = s + 48'h1;
    end
    return {s, ns[31:0], fr[15:0]};
  endfunction

  // long time to the short layout: whole time in nanoseconds over the fraction
  function automatic logic [63:0] to_short(input logic [95:0] t);
    logic [47:0] n;
    n = t[95:48] * {16'h0, NS_WRAP} + {16'h0, t[47:16]};
    return {n, t[15:0]};
  endfunction

  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ===================================================================
  // register port and packet drivers
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk({64'h0, rdata_o}, {64'h0, exp});
  endtask

  task automatic send(input pts_mode_e m, input pts_cksum_e ck, input logic ay, input logic [63:0] c);
    @(posedge clk_i);
    mode_i <= m;
    cksum_i <= ck;
    asym_i <= ay;
    corr_i <= c;
    fingerprint_i <= FP_W'($urandom);
    offset_i <= OFS_W'($urandom);
    fmt_v1_i <= 1'($urandom);
    send_i <= 1'b1;
  endtask

  // bounded wait until every expected answer has been seen
  task automatic drain;
    int n;
    @(posedge clk_i);
    send_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    for (n = 0; n < 40 && stamp_q.size() + edit_q.size() > 0; n++) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
    if (stamp_q.size() + edit_q.size() > 0) begin
      err_total++;
      finish_test();
    end
  endtask

  // ===================================================================
  // reference model fed from the link, compared at every answer
  always @(posedge clk_i) begin
    if (!reset_i) begin
      ex = tadd(tadd(link.tx_clock_time_long_in, CORE_LATENCY), {64'h0, extra_m});
      if (link.sop && link.two_step_req && cfg_long) stamp_q.push_back({link.fingerprint, ex});
      cx = link.corr_in + to_short(ex) - (link.fmt_short ? link.ingress_short : to_short(link.ingress_long))
        + (link.asym_include ? {16'h0, asym_m, 16'h0} : 64'h0);
      if (link.sop && link.insert_req && cfg_long)
        edit_q.push_back({1'b1, 2'h1, link.stamp_offset, link.cksum_fix, link.cksum_zero,
          link.fmt_v1 ? {ex[79:48], ex[47:16]} : ex[63:0]});
      // short-only exit time is not modelled, so its correction value is not compared
      if (link.sop && link.correct_req)
        edit_q.push_back({cfg_long, 2'h2, link.corr_offset, link.cksum_fix, link.cksum_zero, cx});
      if (stamp_valid_o) chk(stamp_o, last_long);
      if (link.exit_stamp_long_strobe) begin
        last_long = link.exit_stamp_long_out;
        if (stamp_q.size() == 0) chk(96'h1, 96'h0);
        else begin
          st = stamp_q.pop_front();
          chk(link.exit_stamp_long_out, st[95:0]);
          chk({80'h0, link.fp_long_out, link.fp_short_out}, {80'h0, st[103:96], st[103:96]});
          chk({31'h0, link.exit_stamp_short_strobe, link.exit_stamp_short_out},
            {31'h0, 1'b1, to_short(st[95:0])});
        end
      end
      if (link.edit_strobe) begin
        if (edit_q.size() == 0) chk(96'h1, 96'h0);
        else begin
          ed = edit_q.pop_front();
          chk({76'h0, link.edit_kind, link.edit_offset, link.edit_cksum}, {76'h0, ed[83:64]});
          if (ed[84]) chk({32'h0, link.edit_value}, {32'h0, ed[63:0]});
          if (link.edit_kind == 2'h2) corr_seen.push_back(link.edit_value);
        end
      end
    end
  end

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  // ===================================================================
  // main sequence
  initial begin
    void'($urandom(32'hDB8E));
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    reg_rd(ADDR_CFG, {30'h0, CFG_RESET});
    reg_rd(ADDR_EXTRA, 32'h0);
    reg_wr(4'hF, 32'hFFFFFFFF);
    reg_rd(ADDR_EXTRA, 32'h0);
    extra_m = 32'h00008000;
    reg_wr(ADDR_EXTRA, extra_m);
    reg_rd(ADDR_EXTRA, extra_m);
    // near-wrapping tick forces ns carries; one-step controls random and ignored
    tick_i <= {48'h0, 32'h3B9AC9F6, 16'hC000};
    repeat (3) begin
      for (i = 0; i < 4; i++) send(MODE_TWO_STEP, pts_cksum_e'($urandom_range(2)), 1'($urandom), 64'($urandom));
      drain();
    end
    for (i = 0; i < 3; i++) send(MODE_INSERT, pts_cksum_e'(i), 1'b0, 64'h0);
    drain();
    // frozen time: only asymmetry and incoming correction move the result
    asym_m = 32'h00000007;
    reg_wr(ADDR_ASYM, asym_m);
    tick_i <= '0;
    ingress_i <= {32'h0, 32'($urandom), 32'($urandom)};
    send(MODE_CORRECT, CK_FIX, 1'b0, 64'h0000012300000000);
    send(MODE_CORRECT, CK_FIX, 1'b1, 64'h0000012300000000);
    send(MODE_CORRECT, CK_ZERO, 1'b0, 64'h0000012300010000);
    drain();
    chk(corr_seen.size(), 96'h3);
    chk({32'h0, corr_seen[1] - corr_seen[0]}, 96'h70000);
    chk({32'h0, corr_seen[2] - corr_seen[0]}, 96'h10000);
    // short ingress format chosen for one packet; set while the line is idle
    fmt_short_i <= 1'b1;
    send(MODE_CORRECT, CK_ZERO, 1'b1, 64'h0000000500000000);
    drain();
    fmt_short_i <= 1'b0;
    // short-only build refuses two-step and insert, keeps correction
    cfg_long = 1'b0;
    reg_wr(ADDR_CFG, 32'h2);
    send(MODE_TWO_STEP, CK_KEEP, 1'b0, 64'h0);
    send(MODE_INSERT, CK_KEEP, 1'b0, 64'h0);
    send(MODE_CORRECT, CK_KEEP, 1'b0, 64'h0);
    drain();
    reg_wr(ADDR_CFG, 32'h3);
    cfg_long = 1'b1;
    send(MODE_TWO_STEP, CK_KEEP, 1'b0, 64'h0);
    drain();
    finish_test();
  end
endmodule // pts_stamp_unit_tb_top
